// *** include/psr_pkg.sv ***
// Package with register addresses, field positions and reset values
package psr_pkg;

   // ----------------------------------------------------------------------
   // Register addresses on the management interface
   // ----------------------------------------------------------------------
   localparam logic [4:0] PSR_ADDR_STATUS  = 5'h01; // Basic status word
   localparam logic [4:0] PSR_ADDR_ID_HIGH = 5'h02; // Identifier, high word
   localparam logic [4:0] PSR_ADDR_ID_LOW  = 5'h03; // Identifier, low word

   // ----------------------------------------------------------------------
   // Basic status word bit positions
   // ----------------------------------------------------------------------
   localparam int PSR_BIT_ANEG_ABLE = 3; // Negotiation ability
   localparam int PSR_BIT_LINK      = 2; // Link status, latch low
   localparam int PSR_BIT_JABBER    = 1; // Jabber detect, latch high
   localparam int PSR_BIT_EXT_CAP   = 0; // Extended capability

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic PSR_LINK_RST   = 1'h0; // Link bit after reset
   localparam logic PSR_JABBER_RST = 1'h0; // Jabber bit after reset
   localparam logic PSR_ANEG_ABLE  = 1'h1; // Constant ability bit
   localparam logic PSR_EXT_CAP    = 1'h1; // Constant extended bit

   // ----------------------------------------------------------------------
   // Identifier field widths
   // ----------------------------------------------------------------------
   localparam int PSR_ORG_W   = 24; // Organisation identifier width
   localparam int PSR_MODEL_W = 6;  // Vendor model field width
   localparam int PSR_REV_W   = 4;  // Model revision field width

   // Read path states
   typedef enum logic [0:0] {
      PSR_IDLE = 1'b0,
      PSR_HOLD = 1'b1
   } psr_rd_state_t;

endpackage

// *** rtl/psr_id_word.sv ***
// Identifier word builder: packs identity fields into two 16-bit words
`timescale 1ns/1ps
module psr_id_word
   import psr_pkg::*;
#(
   parameter logic [PSR_ORG_W-1:0]   ORG_ID   = 24'h000000, // Arbitrary value
   parameter logic [PSR_MODEL_W-1:0] MODEL_ID = 6'h00,      // Arbitrary value
   parameter logic [PSR_REV_W-1:0]   REV_ID   = 4'h0,       // Arbitrary value
   parameter bit                     ID_ZERO  = 1'b0        // Report all zero
)(
   input  wire logic        clock,        // System clock
   input  wire logic        rst,          // Synchronous reset
   output logic [15:0]      id_word_high, // Organisation bits 3..18
   output logic [15:0]      id_word_low   // Org 19..24, model, revision
);

   // ----------------------------------------------------------------------
   // Field mapping
   // ----------------------------------------------------------------------
   // Organisation id numbered 1..24 from the MSB; bits 1 and 2 dropped
   logic [15:0] org_identifier_high;   // Org bits 3..18
   logic [5:0]  org_identifier_low_bits; // Org bits 19..24
   assign org_identifier_high     = ORG_ID[21:6];
   assign org_identifier_low_bits = ORG_ID[5:0];

   // Registered words, constant after reset
   always_ff @(posedge clock) begin
      if (rst || ID_ZERO) begin
         // Zero identifier option or reset
         id_word_high <= 16'h0000;
         id_word_low  <= 16'h0000;
      end else begin
         id_word_high <= org_identifier_high;
         id_word_low  <= {org_identifier_low_bits,
                          MODEL_ID,
                          REV_ID};
      end
   end

endmodule

// *** rtl/psr_status_regs.sv ***
// Status and identifier registers of the management register space
`timescale 1ns/1ps
module psr_status_regs
   import psr_pkg::*;
#(
   parameter logic [PSR_ORG_W-1:0]   ORG_ID   = 24'h000000, // Arbitrary value
   parameter logic [PSR_MODEL_W-1:0] MODEL_ID = 6'h00,      // Arbitrary value
   parameter logic [PSR_REV_W-1:0]   REV_ID   = 4'h0,       // Arbitrary value
   parameter bit                     ID_ZERO  = 1'b0        // Zero identifier
)(
   input  wire logic        clock,      // 20 MHz clock
   input  wire logic        rst,        // Synchronous reset, active high
   input  wire logic        rd_en,      // One-cycle read strobe
   input  wire logic        wr_en,      // One-cycle write strobe
   input  wire logic [4:0]  reg_addr,   // Register address
   input  wire logic [15:0] wr_data,    // Write data, ignored here
   input  wire logic        link_good,  // Link valid condition level
   input  wire logic        jabber_det, // Jabber condition level
   input  wire logic        speed_10,   // High while running at 10 Mb/s
   output logic [15:0]      rd_data,    // Read data, valid with rd_valid
   output logic             rd_valid,   // One-cycle read answer
   output logic             link_up     // Latched link bit, registered one cycle later
);

   // ----------------------------------------------------------------------
   // Internal state
   // ----------------------------------------------------------------------
   logic        link_r;        // Latched-low link bit
   logic        jabber_r;      // Latched-high jabber bit
   logic [15:0] id_word_high;  // Identifier high word
   logic [15:0] id_word_low;   // Identifier low word
   logic [15:0] basic_status_word; // Assembled status word
   logic        status_rd;     // Read of the status word this cycle

   // Status read detect
   assign status_rd = rd_en && (reg_addr == PSR_ADDR_STATUS);

   // ----------------------------------------------------------------------
   // Identifier words
   // ----------------------------------------------------------------------
   psr_id_word #(
      .ORG_ID   (ORG_ID),
      .MODEL_ID (MODEL_ID),
      .REV_ID   (REV_ID),
      .ID_ZERO  (ID_ZERO)
   ) u_id (
      .clock        (clock),
      .rst          (rst),
      .id_word_high (id_word_high),
      .id_word_low  (id_word_low)
   );

   // ----------------------------------------------------------------------
   // Link bit, latched low
   // ----------------------------------------------------------------------
   // Failure clears at once; only a read with good link may set it again
   always_ff @(posedge clock) begin
      if (rst) begin
         link_r <= PSR_LINK_RST;
      end else if (!link_good) begin
         // Failure wins over a read in the same cycle
         link_r <= 1'b0;
      end else if (status_rd) begin
         // Read refreshes the latch to the live good state
         link_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Jabber bit, latched high
   // ----------------------------------------------------------------------
   // A jabber event in the reading cycle wins over the clear by read
   always_ff @(posedge clock) begin
      if (rst) begin
         jabber_r <= PSR_JABBER_RST;
      end else if (jabber_det && speed_10) begin
         // Only counted at 10 Mb/s
         jabber_r <= 1'b1;
      end else if (status_rd) begin
         jabber_r <= 1'b0;
      end
   end

   // Status word as read: reserved upper bits outside this block read 0
   always_comb begin
      basic_status_word = 16'h0000;
      basic_status_word[PSR_BIT_ANEG_ABLE] = PSR_ANEG_ABLE;
      basic_status_word[PSR_BIT_LINK]      = link_r;
      basic_status_word[PSR_BIT_JABBER]    = jabber_r;
      basic_status_word[PSR_BIT_EXT_CAP]   = PSR_EXT_CAP;
   end

   // ----------------------------------------------------------------------
   // Read answer path
   // ----------------------------------------------------------------------
   // Answer one cycle after the strobe with the value before any clear
   always_ff @(posedge clock) begin
      if (rst) begin
         rd_data    <= 16'h0000;
         rd_valid   <= 1'b0;
      end else begin
         rd_valid   <= rd_en;
         if (rd_en) begin
            // Address decode; writes never touch these registers
            if (reg_addr == PSR_ADDR_STATUS) begin
               rd_data <= basic_status_word;
            end else if (reg_addr == PSR_ADDR_ID_HIGH) begin
               rd_data <= id_word_high;
            end else if (reg_addr == PSR_ADDR_ID_LOW) begin
               rd_data <= id_word_low;
            end else begin
               // Unmapped addresses read as zero
               rd_data <= 16'h0000;
            end
         end
      end
   end

   // Link output, latched bit delayed by one cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         link_up <= PSR_LINK_RST;
      end else begin
         link_up <= link_r;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   // Link latch: failure clears it, only a read with good link sets it
   a_link_fail_clr: assert property (
      @(posedge clock) disable iff (rst)
      !link_good |=> !link_r)
      else $error("link bit not cleared after failure");

   a_link_no_self: assert property (
      @(posedge clock) disable iff (rst)
      (!link_r && !status_rd) |=> !link_r)
      else $error("link bit set without a read");

   a_link_rd_set: assert property (
      @(posedge clock) disable iff (rst)
      (status_rd && link_good) |=> link_r)
      else $error("link bit not set on read with good link");

   // Jabber latch: set at 10 Mb/s, held until a status read or reset
   a_jab_hold: assert property (
      @(posedge clock) disable iff (rst)
      (jabber_r && !status_rd) |=> jabber_r)
      else $error("jabber bit dropped without read");

   a_jab_speed: assert property (
      @(posedge clock) disable iff (rst)
      (!jabber_r && !speed_10) |=> !jabber_r)
      else $error("jabber set outside 10 Mb/s");

   a_jab_set: assert property (
      @(posedge clock) disable iff (rst)
      (jabber_det && speed_10) |=> jabber_r)
      else $error("jabber not latched");

   // Status answer: constant bits, and the latches as they were at the read
   a_status_const: assert property (
      @(posedge clock) disable iff (rst)
      (rd_en && reg_addr == PSR_ADDR_STATUS) |=>
      (rd_valid && rd_data[3] && rd_data[0] && rd_data[15:4] == 12'h000))
      else $error("status constant bits wrong");

   a_status_link: assert property (
      @(posedge clock) disable iff (rst)
      (rd_en && reg_addr == PSR_ADDR_STATUS) |=>
      rd_data[2] == $past(link_r))
      else $error("status link bit mismatch");

   a_status_jab: assert property (
      @(posedge clock) disable iff (rst)
      (rd_en && reg_addr == PSR_ADDR_STATUS) |=>
      rd_data[1] == $past(jabber_r))
      else $error("status jabber bit mismatch");

   // Identifier words; a read on the first edge after reset sees them unset
   a_id_low: assert property (
      @(posedge clock) disable iff (rst)
      (rd_en && reg_addr == PSR_ADDR_ID_LOW && !ID_ZERO
       && !$past(rst)) |=>
      rd_data == {ORG_ID[5:0], MODEL_ID, REV_ID})
      else $error("identifier low word wrong");

   a_id_high: assert property (
      @(posedge clock) disable iff (rst)
      (rd_en && reg_addr == PSR_ADDR_ID_HIGH && !ID_ZERO
       && !$past(rst)) |=>
      rd_data == ORG_ID[21:6])
      else $error("identifier high word wrong");

   a_id_zero: assert property (
      @(posedge clock) disable iff (rst)
      (rd_en && ID_ZERO && (reg_addr == PSR_ADDR_ID_HIGH
       || reg_addr == PSR_ADDR_ID_LOW)) |=> rd_data == 16'h0000)
      else $error("zero identifier not zero");

   // Writes leave both latches alone while no live event is pending
   a_write_none: assert property (
      @(posedge clock) disable iff (rst)
      (wr_en && !rd_en && link_good && !(jabber_det && speed_10)) |=>
      (link_r == $past(link_r) && jabber_r == $past(jabber_r)))
      else $error("write changed a status bit");

   // Main scenarios reached
   c_link_recover: cover property (@(posedge clock) disable iff (rst)
      !link_r ##1 (status_rd && link_good) ##1 link_r);
   c_jab_clear: cover property (@(posedge clock) disable iff (rst)
      jabber_r ##1 status_rd ##1 !jabber_r);
   c_id_read: cover property (@(posedge clock) disable iff (rst)
      rd_en && reg_addr == PSR_ADDR_ID_LOW);
   c_unmapped: cover property (@(posedge clock) disable iff (rst)
      rd_en && reg_addr == 5'h1F);
   c_write_seen: cover property (@(posedge clock) disable iff (rst)
      wr_en && wr_data != 16'h0000);

endmodule

// *** testbench/psr_mgmt_model.sv ***
// Station manager model that issues single register reads and writes
`timescale 1ns/1ps
module psr_mgmt_model (
   input  wire logic        clock,    // System clock
   output logic             rd_en,    // Read strobe
   output logic             wr_en,    // Write strobe
   output logic [4:0]       reg_addr, // Register address
   output logic [15:0]      wr_data,  // Write data
   input  wire logic [15:0] rd_data,  // Read answer
   input  wire logic        rd_valid  // Answer strobe
);
   // ----------------------------------------------------------------------
   // Idle values at time zero
   // ----------------------------------------------------------------------
   initial begin
      rd_en    = 1'b0;
      wr_en    = 1'b0;
      reg_addr = 5'h00;
      wr_data  = 16'h0000;
   end

   // One access: strobe held for one edge, released lines show inverses
   task automatic access(input logic wr, input logic [4:0] a,
                         input logic [15:0] d, output logic [15:0] q,
                         output logic v);
      @(posedge clock);
      rd_en    <= !wr;
      wr_en    <= wr;
      reg_addr <= a;
      wr_data  <= d;
      @(posedge clock);
      rd_en    <= 1'b0;
      wr_en    <= 1'b0;
      reg_addr <= ~a;
      wr_data  <= ~d;
      // Answer stands in the cycle after the taking edge; take it at the
      // rising edge that closes that cycle, before the design moves on
      @(posedge clock);
      q = rd_data;
      v = rd_valid;
   endtask
endmodule

// *** testbench/tb_phy_status_and_identity_regs.sv ***
// Self-checking testbench for the status and identifier registers
`timescale 1ns/1ps
module tb_phy_status_and_identity_regs;
   import psr_pkg::*;
   // ----------------------------------------------------------------------
   // Signals and identity values
   // ----------------------------------------------------------------------
   localparam logic [23:0] ORG   = 24'hA5C3E1; // Arbitrary value
   localparam logic [5:0]  MODEL = 6'h2B;      // Arbitrary value
   localparam logic [3:0]  REV   = 4'h9;       // Arbitrary value
   logic        clock = 1'b0;     // 20 MHz clock
   logic        rst = 1'b1;       // Synchronous reset
   logic        link_good = 1'b1; // Live link level
   logic        jabber_det = 1'b0; // Live jabber level
   logic        speed_10 = 1'b1;  // Speed select
   logic        rd_en, wr_en, rd_valid, link_up;
   logic [4:0]  reg_addr;
   logic [15:0] wr_data, rd_data, rd_data_z;
   int          err_total = 0;
   int          samples_checked = 0;
   int          cycles = 0;

   always #25 clock = ~clock;

   psr_status_regs #(.ORG_ID(ORG), .MODEL_ID(MODEL), .REV_ID(REV))
   u_psr_status_regs (.clock(clock), .rst(rst), .rd_en(rd_en),
      .wr_en(wr_en), .reg_addr(reg_addr), .wr_data(wr_data),
      .link_good(link_good), .jabber_det(jabber_det), .speed_10(speed_10),
      .rd_data(rd_data), .rd_valid(rd_valid), .link_up(link_up));

   // Second instance reporting an all-zero identifier
   psr_status_regs #(.ORG_ID(ORG), .MODEL_ID(MODEL), .REV_ID(REV),
      .ID_ZERO(1'b1))
   u_psr_status_regs_z (.clock(clock), .rst(rst), .rd_en(rd_en),
      .wr_en(wr_en), .reg_addr(reg_addr), .wr_data(wr_data),
      .link_good(link_good), .jabber_det(jabber_det), .speed_10(speed_10),
      .rd_data(rd_data_z), .rd_valid(), .link_up());

   psr_mgmt_model u_psr_mgmt_model (.clock(clock), .rd_en(rd_en),
      .wr_en(wr_en), .reg_addr(reg_addr), .wr_data(wr_data),
      .rd_data(rd_data), .rd_valid(rd_valid));

   // ----------------------------------------------------------------------
   // Shared helpers
   // ----------------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Read one register and compare data and answer strobe
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] q;
      logic        v;
      u_psr_mgmt_model.access(1'b0, a, 16'h0000, q, v);
      check({15'h0000, v}, 16'h0001);
      check(q, exp);
   endtask

   // Write one register; no answer strobe may follow
   task automatic wr(input logic [4:0] a);
      logic [15:0] q;
      logic        v;
      u_psr_mgmt_model.access(1'b1, a, 16'hFFFF, q, v);
      check({15'h0000, v}, 16'h0000);
   endtask

   // One-cycle pulse on a live condition input
   task automatic pulse_link_fail();
      @(posedge clock);
      link_good <= 1'b0;
      @(posedge clock);
      link_good <= 1'b1;
   endtask

   task automatic pulse_jabber();
      @(posedge clock);
      jabber_det <= 1'b1;
      @(posedge clock);
      jabber_det <= 1'b0;
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic test_reset_values();
      rd(PSR_ADDR_STATUS, 16'h0009);
      rd(PSR_ADDR_STATUS, 16'h000D);
      check({15'h0000, link_up}, 16'h0001);
      $display("test_reset_values done");
   endtask

   task automatic test_link_latch();
      pulse_link_fail();
      rd(PSR_ADDR_STATUS, 16'h0009);
      rd(PSR_ADDR_STATUS, 16'h000D);
      $display("test_link_latch done");
   endtask

   task automatic test_jabber_latch();
      pulse_jabber();
      repeat (3) @(posedge clock);
      rd(PSR_ADDR_STATUS, 16'h000F);
      rd(PSR_ADDR_STATUS, 16'h000D);
      @(posedge clock);
      speed_10 <= 1'b0;
      pulse_jabber();
      rd(PSR_ADDR_STATUS, 16'h000D);
      speed_10 <= 1'b1;
      $display("test_jabber_latch done");
   endtask

   // Words for org A5C3E1, model 2B, revision 9: org bits 3..18 give
   // 970F; org bits 19..24, then model, then revision give 86B9
   task automatic test_identifier();
      rd(PSR_ADDR_ID_HIGH, 16'h970F);
      check(rd_data_z, 16'h0000);
      rd(PSR_ADDR_ID_LOW, 16'h86B9);
      check(rd_data_z, 16'h0000);
      rd(5'h1F, 16'h0000);
      $display("test_identifier done");
   endtask

   task automatic test_writes_ignored();
      pulse_jabber();
      wr(PSR_ADDR_STATUS);
      wr(PSR_ADDR_ID_HIGH);
      wr(PSR_ADDR_ID_LOW);
      rd(PSR_ADDR_STATUS, 16'h000F);
      rd(PSR_ADDR_ID_HIGH, 16'h970F);
      rd(PSR_ADDR_ID_LOW, 16'h86B9);
      $display("test_writes_ignored done");
   endtask

   // Failure and jabber in the very cycle of a status read beat the read
   task automatic test_same_cycle();
      fork
         rd(PSR_ADDR_STATUS, 16'h000D);
         begin
            @(posedge clock);
            link_good  <= 1'b0;
            jabber_det <= 1'b1;
            @(posedge clock);
            link_good  <= 1'b1;
            jabber_det <= 1'b0;
         end
      join
      rd(PSR_ADDR_STATUS, 16'h000B);
      rd(PSR_ADDR_STATUS, 16'h000D);
      $display("test_same_cycle done");
   endtask

   // Reset in mid-run clears both latches and reloads the identifier
   task automatic test_mid_reset();
      pulse_jabber();
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      check({15'h0000, link_up}, 16'h0000);
      rd(PSR_ADDR_STATUS, 16'h0009);
      rd(PSR_ADDR_ID_LOW, 16'h86B9);
      $display("test_mid_reset done");
   endtask

   // ----------------------------------------------------------------------
   // Verdict, timeout and main sequence
   // ----------------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Cuts a hang short well beyond the expected run of under 100 cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         err_total++;
         complete_run();
      end
   end

   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      test_reset_values();
      test_link_latch();
      test_jabber_latch();
      test_identifier();
      test_writes_ignored();
      test_same_cycle();
      test_mid_reset();
      complete_run();
   end
endmodule
